// *** i2cm_pkg.sv ***
package i2cm_pkg;
   // Register map
   localparam logic [7:0] ADR_TXBUF = 8'h9A;
   localparam logic [7:0] ADR_RXBUF = 8'h9B;
   localparam logic [7:0] ADR_MODE  = 8'hE8;
   localparam logic [7:0] ADR_ADDR  = 8'hE9;
   localparam logic [7:0] ADR_STAT  = 8'hEA;
   // Reset values
   localparam logic [7:0] RST_MODE  = 8'h00;
   localparam logic [7:0] RST_ADDR  = 8'h00;
   localparam logic [7:0] RST_RXBUF = 8'h00;
   // Mode fields
   localparam int MODE_EN      = 7;
   localparam int MODE_DIV_HI  = 6;
   localparam int MODE_DIV_LO  = 5;
   localparam int MODE_LEN_HI  = 4;
   // Status fields
   localparam int STAT_BUSY    = 7;
   localparam int STAT_NOACK   = 6;
   localparam int STAT_RXIRQ   = 5;
   localparam int STAT_TXIRQ   = 4;
   localparam int STAT_ACCERR  = 1;
   localparam int STAT_TXWRERR = 0;
   localparam logic [1:0] FST_EMPTY = 2'h0;
   localparam logic [1:0] FST_HALF  = 2'h2;
   localparam logic [1:0] FST_FULL  = 2'h3;
   // Serial clock: period is 16 << divider core cycles, four phases per bit
   localparam int         SCL_DIV_BASE = 16;
   localparam int         SCL_PHASES   = 4;
   localparam logic [7:0] QTR_BASE     = 8'(SCL_DIV_BASE / SCL_PHASES);
   localparam int         FAST_KHZ     = 256;
   localparam int         STD_KHZ      = 32;
   // Byte framing
   localparam int         FIFO_DEPTH   = 4;
   localparam logic [3:0] ACK_SLOT     = 4'h8;
   localparam logic [3:0] DECIDE_SLOT  = 4'h9;
   typedef enum logic [1:0] {I2CM_IDLE, I2CM_START, I2CM_BIT, I2CM_STOP} i2cm_state_e;
endpackage

// *** i2cm_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none
module i2cm_fifo
   import i2cm_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   // Control
   input  wire logic       flush_i,
   input  wire logic       push_i,
   input  wire logic [7:0] push_data_i,
   input  wire logic       pop_i,
   // State
   output logic      [7:0] head_o,
   output logic      [2:0] count_o
);
   logic [7:0] mem_r [FIFO_DEPTH];
   logic [7:0] mem_nxt [FIFO_DEPTH];
   logic [1:0] wr_r, wr_nxt, rd_r, rd_nxt;
   logic [2:0] cnt_nxt;
   logic [7:0] head_nxt;
   logic       do_push, do_pop;

   always_comb begin
      do_pop  = pop_i && (count_o != 3'h0);
      do_push = push_i && (count_o != 3'(FIFO_DEPTH));
      mem_nxt = mem_r;
      wr_nxt  = wr_r;
      rd_nxt  = rd_r;
      cnt_nxt = count_o;
      if (flush_i) begin
         wr_nxt  = 2'h0;
         rd_nxt  = 2'h0;
         cnt_nxt = 3'h0;
      end else begin
         if (do_push) begin
            mem_nxt[wr_r] = push_data_i;
            wr_nxt        = wr_r + 2'h1;
         end
         if (do_pop) begin
            rd_nxt = rd_r + 2'h1;
         end
         cnt_nxt = count_o + {2'h0, do_push} - {2'h0, do_pop};
      end
      head_nxt = (cnt_nxt == 3'h0) ? RST_RXBUF : mem_nxt[rd_nxt];
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         wr_r    <= 2'h0;
         rd_r    <= 2'h0;
         count_o <= 3'h0;
         head_o  <= RST_RXBUF;
         for (int i = 0; i < FIFO_DEPTH; i++) begin
            mem_r[i] <= 8'h00;
         end
      end else begin
         wr_r    <= wr_nxt;
         rd_r    <= rd_nxt;
         count_o <= cnt_nxt;
         head_o  <= head_nxt;
         mem_r   <= mem_nxt;
      end
   end
endmodule
`default_nettype wire

// *** i2cm_master_port.sv ***
// Operation
// - Master drives serial clock; fast and standard rates reachable by divider.
// - Serial clock is core clock over 16 times two to divider field.
// - Mode bit 7 enables interface; no transfer starts while clear.
// - Writing the address register starts a transaction with that address.
// - Address register holds seven-bit target above the direction bit.
// - Direction 1 reads into receive buffer; 0 writes from transmit buffer.
// - Read stops after length field plus one bytes, or on error.
// - Mode, address and status registers sit at the shared addresses.
// - Transmit buffer write-only at 0x9A; receive buffer read-only, resets zero.
// - One four-byte FIFO serves receive or transmit, one at a time.
// - Reads acknowledge automatically and not-acknowledge the final byte.
// - Address rewrite mid-transaction gives repeated start instead of stop.
// - Missing slave acknowledge sets no-ack flag and stops; write zero clears.
`timescale 1ns/10ps
`default_nettype none
module i2cm_master_port
   import i2cm_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   // Register port
   input  wire logic [7:0] sfr_addr_i,
   input  wire logic       sfr_wr_i,
   input  wire logic       sfr_rd_i,
   input  wire logic [7:0] sfr_wdata_i,
   output logic      [7:0] sfr_rdata_o,
   // Serial clock pin
   input  wire logic       scl_i,
   output logic            scl_o,
   output logic            scl_oen_o,
   // Serial data pin
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oen_o
);
   i2cm_state_e state_r, state_nxt;
   logic [7:0] mode_r, mode_nxt, addr_r, addr_nxt, cur_addr_r, cur_addr_nxt;
   logic [7:0] shift_r, shift_nxt, div_cnt_r, div_cnt_nxt, rdata_nxt, qtr_last;
   logic [1:0] phase_r, phase_nxt;
   logic [3:0] bit_cnt_r, bit_cnt_nxt;
   logic [4:0] byte_cnt_r, byte_cnt_nxt;
   logic       rd_mode_r, rd_mode_nxt, is_addr_r, is_addr_nxt, ack_r, ack_nxt;
   logic       restart_r, restart_nxt, scl_r, scl_nxt, sda_r, sda_nxt;
   logic       noack_r, noack_nxt, rxirq_r, rxirq_nxt, txirq_r, txirq_nxt;
   logic       accerr_r, accerr_nxt, txwr_r, txwr_nxt;
   logic [2:0] scl_s_r, sda_s_r;
   logic       scl_in_r, sda_in_r, zero_r;
   logic       tick, hold, ready, rx_byte, last_rx, busy, en;
   logic       wr_tx, rd_rx, wr_adr, wr_stat;
   logic       f_flush, f_push, f_pop;
   logic [7:0] f_pdata, f_head;
   logic [2:0] f_count;
   logic [1:0] fstat;

   i2cm_fifo u_fifo (
      .clk_i       (clk_i),
      .reset_n_i   (reset_n_i),
      .flush_i     (f_flush),
      .push_i      (f_push),
      .push_data_i (f_pdata),
      .pop_i       (f_pop),
      .head_o      (f_head),
      .count_o     (f_count)
   );

   // Pin synchronisers, a change counts once stages two and three agree
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         scl_s_r  <= 3'h7;
         sda_s_r  <= 3'h7;
         scl_in_r <= 1'b1;
         sda_in_r <= 1'b1;
         zero_r   <= 1'b0;
      end else begin
         scl_s_r  <= {scl_s_r[1:0], scl_i};
         sda_s_r  <= {sda_s_r[1:0], sda_i};
         zero_r   <= 1'b0;
         if (scl_s_r[1] == scl_s_r[2]) begin
            scl_in_r <= scl_s_r[2];
         end
         if (sda_s_r[1] == sda_s_r[2]) begin
            sda_in_r <= sda_s_r[2];
         end
      end
   end

   always_comb begin
      en       = mode_r[MODE_EN];
      busy     = (state_r != I2CM_IDLE);
      wr_tx    = sfr_wr_i && (sfr_addr_i == ADR_TXBUF);
      rd_rx    = sfr_rd_i && (sfr_addr_i == ADR_RXBUF);
      wr_adr   = sfr_wr_i && (sfr_addr_i == ADR_ADDR);
      wr_stat  = sfr_wr_i && (sfr_addr_i == ADR_STAT);
      rx_byte  = rd_mode_r && !is_addr_r;
      last_rx  = (byte_cnt_r == mode_r[MODE_LEN_HI:0]);
      // Stall only while another received byte must still fit
      ready    = !(rx_byte && !last_rx && ack_r && (f_count == 3'(FIFO_DEPTH)));
      qtr_last = 8'((QTR_BASE << mode_r[MODE_DIV_HI:MODE_DIV_LO]) - 8'h01);
      // Agreeing stages end the high phase without an extra register delay
      hold     = ((phase_r == 2'h1) && !(scl_in_r || (scl_s_r[1] && scl_s_r[2])))
               || ((state_r == I2CM_BIT) && (bit_cnt_r == DECIDE_SLOT) && !ready);
      tick     = busy && (div_cnt_r == qtr_last) && !hold;
      fstat    = (f_count == 3'(FIFO_DEPTH)) ? FST_FULL : (f_count >= 3'h2) ? FST_HALF : FST_EMPTY;
   end

   always_comb begin
      state_nxt    = state_r;
      phase_nxt    = phase_r;
      bit_cnt_nxt  = bit_cnt_r;
      byte_cnt_nxt = byte_cnt_r;
      shift_nxt    = shift_r;
      rd_mode_nxt  = rd_mode_r;
      is_addr_nxt  = is_addr_r;
      ack_nxt      = ack_r;
      restart_nxt  = restart_r;
      cur_addr_nxt = cur_addr_r;
      scl_nxt      = scl_r;
      sda_nxt      = sda_r;
      mode_nxt     = mode_r;
      addr_nxt     = addr_r;
      noack_nxt    = noack_r;
      rxirq_nxt    = rxirq_r;
      txirq_nxt    = txirq_r;
      accerr_nxt   = accerr_r;
      txwr_nxt     = txwr_r;
      f_flush      = 1'b0;
      f_push       = 1'b0;
      f_pdata      = sfr_wdata_i;
      f_pop        = rd_rx;
      div_cnt_nxt  = !busy ? 8'h00 : (div_cnt_r == qtr_last) ? (hold ? div_cnt_r : 8'h00)
                   : div_cnt_r + 8'h01;
      // Software side; hardware sets below override these clears
      if (sfr_wr_i && (sfr_addr_i == ADR_MODE)) begin
         mode_nxt = sfr_wdata_i;
      end
      if (wr_stat) begin
         noack_nxt  = noack_r & sfr_wdata_i[STAT_NOACK];
         rxirq_nxt  = rxirq_r & sfr_wdata_i[STAT_RXIRQ];
         txirq_nxt  = txirq_r & sfr_wdata_i[STAT_TXIRQ];
         accerr_nxt = accerr_r & sfr_wdata_i[STAT_ACCERR];
         txwr_nxt   = txwr_r & sfr_wdata_i[STAT_TXWRERR];
      end
      if (wr_tx) begin
         if (busy && rd_mode_r) begin
            accerr_nxt = 1'b1;
         end else begin
            f_push = 1'b1;
            if (f_count == 3'(FIFO_DEPTH)) begin
               txwr_nxt = 1'b1;
            end
         end
      end
      if (rd_rx && busy && !rd_mode_r) begin
         accerr_nxt = 1'b1;
      end
      if (wr_adr) begin
         addr_nxt = sfr_wdata_i;
         if (busy) begin
            restart_nxt = 1'b1;
         end else if (en) begin
            state_nxt    = I2CM_START;
            phase_nxt    = 2'h0;
            cur_addr_nxt = sfr_wdata_i;
            shift_nxt    = sfr_wdata_i;
            rd_mode_nxt  = sfr_wdata_i[0];
            is_addr_nxt  = 1'b1;
            byte_cnt_nxt = 5'h00;
            f_flush      = sfr_wdata_i[0];
         end
      end
      if (busy && !en) begin
         state_nxt   = I2CM_IDLE;
         scl_nxt     = 1'b1;
         sda_nxt     = 1'b1;
         restart_nxt = 1'b0;
      end else if (tick) begin
         phase_nxt = phase_r + 2'h1;
         case (state_r)
            I2CM_START: begin
               case (phase_r)
                  2'h0: scl_nxt = 1'b1;
                  2'h1: sda_nxt = 1'b0;
                  2'h2: scl_nxt = 1'b0;
                  default: begin
                     state_nxt   = I2CM_BIT;
                     bit_cnt_nxt = 4'h0;
                     sda_nxt     = shift_r[7];
                  end
               endcase
            end
            I2CM_BIT: begin
               case (phase_r)
                  2'h0: begin
                     if (bit_cnt_r == DECIDE_SLOT) begin
                        phase_nxt   = 2'h0;
                        bit_cnt_nxt = 4'h0;
                        is_addr_nxt = 1'b0;
                        if (!ack_r) begin
                           noack_nxt = 1'b1;
                           state_nxt = I2CM_STOP;
                           sda_nxt   = 1'b0;
                        end else if ((rx_byte && last_rx)
                                     || (!rd_mode_r && (f_count == 3'h0))) begin
                           if (restart_r) begin
                              restart_nxt  = 1'b0;
                              state_nxt    = I2CM_START;
                              sda_nxt      = 1'b1;
                              cur_addr_nxt = addr_r;
                              shift_nxt    = addr_r;
                              rd_mode_nxt  = addr_r[0];
                              is_addr_nxt  = 1'b1;
                              byte_cnt_nxt = 5'h00;
                              f_flush      = addr_r[0];
                           end else begin
                              state_nxt = I2CM_STOP;
                              sda_nxt   = 1'b0;
                           end
                        end else if (rd_mode_r) begin
                           if (rx_byte) begin
                              byte_cnt_nxt = byte_cnt_r + 5'h01;
                           end
                           shift_nxt = 8'h00;
                           sda_nxt   = 1'b1;
                        end else begin
                           f_pop     = 1'b1;
                           shift_nxt = f_head;
                           sda_nxt   = f_head[7];
                           if (f_count == 3'h1) begin
                              txirq_nxt = 1'b1;
                           end
                        end
                     end else begin
                        scl_nxt = 1'b1;
                     end
                  end
                  2'h1: begin
                     if (bit_cnt_r == ACK_SLOT) begin
                        ack_nxt = rx_byte || !sda_in_r;
                     end else begin
                        shift_nxt = {shift_r[6:0], sda_in_r};
                     end
                  end
                  2'h2: scl_nxt = 1'b0;
                  default: begin
                     bit_cnt_nxt = bit_cnt_r + 4'h1;
                     if (bit_cnt_r == ACK_SLOT) begin
                        sda_nxt = 1'b1;
                        if (rx_byte) begin
                           f_push    = 1'b1;
                           f_pdata   = shift_r;
                           rxirq_nxt = 1'b1;
                        end
                     end else if (bit_cnt_r == 4'h7) begin
                        sda_nxt = rx_byte ? last_rx : 1'b1;
                     end else begin
                        sda_nxt = rx_byte ? 1'b1 : shift_r[7];
                     end
                  end
               endcase
            end
            I2CM_STOP: begin
               case (phase_r)
                  2'h0: scl_nxt = 1'b1;
                  2'h1: sda_nxt = 1'b1;
                  2'h2: sda_nxt = 1'b1;
                  default: begin
                     state_nxt   = I2CM_IDLE;
                     restart_nxt = 1'b0;
                  end
               endcase
            end
            default: state_nxt = I2CM_IDLE;
         endcase
      end
      case (sfr_addr_i)
         ADR_RXBUF: rdata_nxt = f_head;
         ADR_MODE:  rdata_nxt = mode_r;
         ADR_ADDR:  rdata_nxt = addr_r;
         ADR_STAT:  rdata_nxt = {busy, noack_r, rxirq_r, txirq_r, fstat, accerr_r, txwr_r};
         default:   rdata_nxt = 8'h00;
      endcase
      if (!sfr_rd_i) begin
         rdata_nxt = sfr_rdata_o;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_r <= I2CM_IDLE;
         phase_r <= 2'h0;
         bit_cnt_r <= 4'h0;
         byte_cnt_r <= 5'h00;
         shift_r <= 8'h00;
         div_cnt_r <= 8'h00;
         {rd_mode_r, is_addr_r, ack_r, restart_r} <= 4'h0;
         {scl_r, sda_r} <= 2'h3;
         {noack_r, rxirq_r, txirq_r, accerr_r, txwr_r} <= 5'h00;
         mode_r <= RST_MODE;
         addr_r <= RST_ADDR;
         cur_addr_r <= RST_ADDR;
         sfr_rdata_o <= 8'h00;
      end else begin
         state_r <= state_nxt;
         phase_r <= phase_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         byte_cnt_r <= byte_cnt_nxt;
         shift_r <= shift_nxt;
         div_cnt_r <= div_cnt_nxt;
         {rd_mode_r, is_addr_r, ack_r, restart_r} <= {rd_mode_nxt, is_addr_nxt, ack_nxt, restart_nxt};
         {scl_r, sda_r} <= {scl_nxt, sda_nxt};
         {noack_r, rxirq_r, txirq_r, accerr_r, txwr_r} <= {noack_nxt, rxirq_nxt, txirq_nxt, accerr_nxt, txwr_nxt};
         mode_r <= mode_nxt;
         addr_r <= addr_nxt;
         cur_addr_r <= cur_addr_nxt;
         sfr_rdata_o <= rdata_nxt;
      end
   end

   // Open-drain: only low is driven, enable low means driving
   assign scl_o     = zero_r;
   assign sda_o     = zero_r;
   assign scl_oen_o = scl_r;
   assign sda_oen_o = sda_r;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   property p_no_start_disabled;
      (state_r == I2CM_IDLE) && !en |=> (state_r == I2CM_IDLE);
   endproperty
   a_no_start_disabled: assert property (p_no_start_disabled) else $error("transfer started while disabled");
   property p_idle_released;
      (state_r == I2CM_IDLE) && $past(state_r == I2CM_IDLE) |-> scl_oen_o && sda_oen_o;
   endproperty
   a_idle_released: assert property (p_idle_released) else $error("bus lines not released while idle");
   property p_div16;
      tick && (mode_r[6:5] == 2'h0) && (phase_r == 2'h2) && en && !sfr_wr_i |=> (!tick)[*3] ##1 tick;
   endproperty
   a_div16: assert property (p_div16) else $error("quarter period not four cycles at divide 16");
   property p_write_starts;
      wr_adr && en && (state_r == I2CM_IDLE) |=> (state_r == I2CM_START) && (shift_r == cur_addr_r);
   endproperty
   a_write_starts: assert property (p_write_starts) else $error("address write did not start");
   property p_dir_taken;
      $rose(busy) |-> (rd_mode_r == cur_addr_r[0]) && is_addr_r;
   endproperty
   a_dir_taken: assert property (p_dir_taken) else $error("direction bit not taken from address");
   property p_nack_flag;
      tick && (state_r == I2CM_BIT) && (bit_cnt_r == DECIDE_SLOT) && !ack_r |=> noack_r && (state_r == I2CM_STOP);
   endproperty
   a_nack_flag: assert property (p_nack_flag) else $error("no-ack not flagged or not stopped");
   property p_master_ack;
      (state_r == I2CM_BIT) && (bit_cnt_r == ACK_SLOT) && rx_byte |-> (sda_r == last_rx);
   endproperty
   a_master_ack: assert property (p_master_ack) else $error("wrong master acknowledge level");
   property p_stop_cond;
      (state_r == I2CM_STOP) && (phase_r == 2'h2) |-> scl_r && sda_r;
   endproperty
   a_stop_cond: assert property (p_stop_cond) else $error("stop condition malformed");
   property p_restart;
      tick && (state_r == I2CM_BIT) && (bit_cnt_r == DECIDE_SLOT) && ack_r && restart_r
         && !rd_mode_r && (f_count == 3'h0) && en |=> (state_r == I2CM_START);
   endproperty
   a_restart: assert property (p_restart) else $error("repeated start not issued");
   property p_rx_empty_zero;
      rd_rx && (f_count == 3'h0) |=> (sfr_rdata_o == RST_RXBUF);
   endproperty
   a_rx_empty_zero: assert property (p_rx_empty_zero) else $error("empty receive buffer not zero");
   property p_rx_limit;
      (state_r == I2CM_BIT) |-> (byte_cnt_r <= mode_r[4:0]) || !rd_mode_r || sfr_wr_i || $past(sfr_wr_i);
   endproperty
   a_rx_limit: assert property (p_rx_limit) else $error("read ran past programmed length");
   c_read_done: cover property (rd_mode_r && (state_r == I2CM_STOP) ##1 (state_r == I2CM_IDLE));
   c_nack: cover property ($rose(noack_r));
   c_restart: cover property ((state_r == I2CM_BIT) ##1 (state_r == I2CM_START));
endmodule
`default_nettype wire

// *** i2cm_slave_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module i2cm_slave_model #(
   parameter logic [6:0] ADDR    = 7'h5A,
   parameter logic [7:0] RD_BASE = 8'hC3
) (
   // Bus wires
   input  wire logic scl,
   input  wire logic sda,
   // Open-drain pull, 1 pulls data low
   output logic      sda_pull
);
   logic [7:0] b;
   logic [7:0] d;
   logic       hit;
   logic       ack;
   logic       rs;
   int         n;
   int         acks;
   int         nacks;
   logic [7:0] got_q[$];

   task automatic rx_byte(output logic [7:0] v);
      for (int i = 7; i >= 0; i--) begin
         @(posedge scl) v[i] = sda;
      end
   endtask

   initial begin
      sda_pull = 1'b0;
      forever begin
         @(negedge sda iff scl);
         // A repeated start opens the next transfer without a stop
         do begin
            rs = 1'b0;
            fork
               begin
                  rx_byte(b);
                  hit = (b[7:1] == ADDR);
                  @(negedge scl) sda_pull = hit;
                  if (hit && !b[0]) begin
                     forever begin
                        @(negedge scl) sda_pull = 1'b0;
                        rx_byte(b);
                        got_q.push_back(b);
                        @(negedge scl) sda_pull = 1'b1;
                     end
                  end
                  if (hit && b[0]) begin
                     n = 0;
                     do begin
                        d = RD_BASE + 8'(n);
                        n++;
                        for (int i = 7; i >= 0; i--) begin
                           @(negedge scl) sda_pull = !d[i];
                        end
                        @(negedge scl) sda_pull = 1'b0;
                        @(posedge scl) ack = !sda;
                        if (ack) acks++; else nacks++;
                     end while (ack);
                  end
               end
               @(posedge sda iff scl);
               @(negedge sda iff scl) rs = 1'b1;
            join_any
            disable fork;
            sda_pull = 1'b0;
         end while (rs);
      end
   end
endmodule
`default_nettype wire

// *** i2c_master_port_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module i2c_master_port_tb;
   import i2cm_pkg::*;
   localparam logic [6:0] SLV = 7'h5A;
   localparam logic [7:0] RDB = 8'hC3;
   logic clk_i, reset_n_i, sfr_wr_i, sfr_rd_i;
   logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, v, b;
   logic scl_o, scl_oen_o, sda_o, sda_oen_o, sda_pull;
   wire  scl = scl_oen_o ? 1'b1 : scl_o;
   wire  sda = sda_oen_o ? !sda_pull : sda_o;
   int error_cnt, comparisons, cyc, rises, n, r0;
   time t_last, min_per;
   logic [7:0] q[$];

   i2cm_master_port u_i2cm_master_port (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
      .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .scl_i(scl),
      .scl_o(scl_o), .scl_oen_o(scl_oen_o), .sda_i(sda), .sda_o(sda_o),
      .sda_oen_o(sda_oen_o));
   i2cm_slave_model #(.ADDR(SLV), .RD_BASE(RDB)) u_i2cm_slave_model (.scl(scl),
      .sda(sda), .sda_pull(sda_pull));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   always @(posedge scl) begin
      rises++;
      if ($time - t_last < min_per) min_per = $time - t_last;
      t_last = $time;
   end

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] dt);
      sfr_addr_i  <= a;
      sfr_wdata_i <= dt;
      sfr_wr_i    <= 1'b1;
      @(posedge clk_i) sfr_wr_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] r);
      sfr_addr_i <= a;
      sfr_rd_i   <= 1'b1;
      @(posedge clk_i) sfr_rd_i <= 1'b0;
      @(posedge clk_i);
      r = sfr_rdata_o;
   endtask
   task automatic wait_idle();
      int k;
      k = 0;
      do begin
         rd(ADR_STAT, v);
         k++;
      end while (v[STAT_BUSY] !== 1'b0 && k < 5000);
      chk("busy", 0, {31'h0, v[STAT_BUSY]});
   endtask

   initial begin
      logic [7:0] regs[6];
      regs = '{8'h9A, 8'h9B, 8'hE8, 8'hE9, 8'hEA, 8'h55};
      {sfr_wr_i, sfr_rd_i, sfr_addr_i, sfr_wdata_i} <= '0;
      reset_n_i <= 1'b0;
      min_per = 1000000;
      void'($urandom(16));
      repeat (6) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      foreach (regs[i]) begin
         rd(regs[i], v);
         chk("reset value", 0, v);
      end
      $display("test reset done");
      r0 = rises;
      wr(ADR_ADDR, {SLV, 1'b0});
      repeat (200) @(posedge clk_i);
      chk("no start", r0, rises);
      $display("test disabled done");
      for (int dv = 0; dv < 4; dv++) begin
         n = $urandom_range(3, 1);
         q.delete();
         u_i2cm_slave_model.got_q.delete();
         wr(ADR_STAT, 8'h00);
         wr(ADR_MODE, {1'b1, 2'(dv), 5'h00});
         for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            q.push_back(b);
            wr(ADR_TXBUF, b);
         end
         min_per = 1000000;
         wr(ADR_ADDR, {SLV, 1'b0});
         wait_idle();
         chk("scl period", (16 << dv) * 20, 32'(min_per));
         chk("wr count", n, u_i2cm_slave_model.got_q.size());
         chk("tx event", 1, v[STAT_TXIRQ]);
         foreach (q[i]) chk("wr byte", q[i], u_i2cm_slave_model.got_q[i]);
      end
      $display("test write done");
      for (int t = 0; t < 3; t++) begin
         n = $urandom_range(3, 0);
         u_i2cm_slave_model.acks = 0;
         u_i2cm_slave_model.nacks = 0;
         wr(ADR_STAT, 8'h00);
         wr(ADR_MODE, {1'b1, 2'b00, 5'(n)});
         wr(ADR_ADDR, {SLV, 1'b1});
         wait_idle();
         chk("acks", n, u_i2cm_slave_model.acks);
         chk("nacks", 1, u_i2cm_slave_model.nacks);
         chk("rx event", 1, v[STAT_RXIRQ]);
         chk("fifo fill", (n == 3) ? 3 : (n > 0) ? 2 : 0, v[3:2]);
         for (int i = 0; i <= n; i++) begin
            rd(ADR_RXBUF, v);
            chk("rd byte", RDB + 8'(i), v);
         end
      end
      $display("test read done");
      u_i2cm_slave_model.got_q.delete();
      u_i2cm_slave_model.acks = 0;
      u_i2cm_slave_model.nacks = 0;
      b = 8'($urandom);
      wr(ADR_MODE, {1'b1, 2'b00, 5'h01});
      wr(ADR_TXBUF, b);
      wr(ADR_ADDR, {SLV, 1'b0});
      wr(ADR_ADDR, {SLV, 1'b1});
      wait_idle();
      chk("rs wr count", 1, u_i2cm_slave_model.got_q.size());
      chk("rs wr byte", b, u_i2cm_slave_model.got_q[0]);
      chk("rs acks", 1, u_i2cm_slave_model.acks);
      for (int i = 0; i < 2; i++) begin
         rd(ADR_RXBUF, v);
         chk("rs rd byte", RDB + 8'(i), v);
      end
      $display("test restart done");
      wr(ADR_ADDR, {SLV ^ 7'h01, 1'b0});
      wait_idle();
      rd(ADR_STAT, v);
      chk("noack set", 1, v[STAT_NOACK]);
      wr(ADR_STAT, 8'h00);
      rd(ADR_STAT, v);
      chk("noack clr", 0, v[STAT_NOACK]);
      for (int i = 0; i < 5; i++) begin
         wr(ADR_TXBUF, 8'(i));
      end
      rd(ADR_STAT, v);
      chk("tx overflow", 1, v[STAT_TXWRERR]);
      chk("fifo full", 3, v[3:2]);
      chk("sda idle", 1, sda_oen_o);
      $display("test noack done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
